// File: core/atsw_params.svh
// Purpose: constants for the sector-write and smart command interpreter
// Assumes: 100 MHz clock, register port with one-cycle read latency
// Notes:   offsets are word indices on the plain register port
`ifndef ATSW_PARAMS_SVH
`define ATSW_PARAMS_SVH

`define ATSW_OFS_DATA        4'h0
`define ATSW_OFS_FEATURE     4'h1
`define ATSW_OFS_SECCNT      4'h2
`define ATSW_OFS_SECNUM      4'h3
`define ATSW_OFS_CYL_LO      4'h4
`define ATSW_OFS_CYL_HI      4'h5
`define ATSW_OFS_DRVHEAD     4'h6
`define ATSW_OFS_CMD_STAT    4'h7
`define ATSW_OFS_IRQ_STAT    4'h8
`define ATSW_OFS_IRQ_MASK    4'h9
`define ATSW_OFS_ERROR       4'ha
`define ATSW_OFS_SMART_CFG   4'hb

`define ATSW_CMD_WRITE       8'h30
`define ATSW_CMD_WRITE_NOER  8'h38
`define ATSW_CMD_SMART       8'hb0

`define ATSW_FEAT_RD_DATA    8'hd0
`define ATSW_FEAT_RD_THR     8'hd1
`define ATSW_FEAT_AUTOSAVE   8'hd2
`define ATSW_FEAT_SAVE_ATTR  8'hd3
`define ATSW_FEAT_OFFLINE    8'hd4
`define ATSW_FEAT_ENABLE     8'hd8
`define ATSW_FEAT_DISABLE    8'hd9
`define ATSW_FEAT_STATUS     8'hda

`define ATSW_SIG_BAD_LO      8'hf4
`define ATSW_SIG_BAD_HI      8'h2c
`define ATSW_SIG_OK_LO       8'h4f
`define ATSW_SIG_OK_HI       8'hc2

`define ATSW_STAT_BSY        7
`define ATSW_STAT_DRDY       6
`define ATSW_STAT_DRQ        3
`define ATSW_STAT_ERR        0
`define ATSW_ERR_ABRT        2
`define ATSW_ERR_IDNF        4

`define ATSW_DH_FIXED7       7
`define ATSW_DH_LBA          6
`define ATSW_DH_FIXED5       5
`define ATSW_DH_DRV          4

`define ATSW_IRQ_CMD         0
`define ATSW_IRQ_DRQ         1
`define ATSW_IRQ_ERR         2

`define ATSW_WORDS_PER_SEC   8'hff
`define ATSW_SEC_256         9'h100

`define ATSW_ERASE_NS        200
`define ATSW_PROG_NS         300
`define ATSW_ERASE_CYC       ((`ATSW_ERASE_NS + 9) / 10)
`define ATSW_PROG_CYC        ((`ATSW_PROG_NS + 9) / 10)

`endif

// File: core/atsw_pkg.sv
// Purpose: types for the sector-write and smart command interpreter
// Assumes: constants come from atsw_params.svh
// Notes:   none
package atsw_pkg;
	typedef enum logic [2:0] {
		ATSW_IDLE,
		ATSW_SETUP,
		ATSW_XFER,
		ATSW_ERASE,
		ATSW_PROG,
		ATSW_DONE
	} atsw_state_e;
	typedef logic [7:0] atsw_byte_t;
endpackage : atsw_pkg

// File: core/atsw_media_timer.sv
// Purpose: busy timer modelling erase and program time of one sector
// Assumes: start is a single-cycle pulse while idle
// Notes:   done pulses one cycle when the count expires
`timescale 1ns/1ps
`include "atsw_params.svh"
module atsw_media_timer (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        rstn_in,
	// control
	input  wire logic        start_in,
	input  wire logic [7:0]  cycles_in,
	output logic             done_out
);
	logic [7:0] cnt_q;
	logic       run_q;

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			cnt_q    <= 8'h00;
			run_q    <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				cnt_q <= cycles_in;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= 8'h01) begin
					run_q    <= 1'b0;
					done_out <= 1'b1;
				end
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule : atsw_media_timer

// File: core/atsw_cmd_core.sv
// Purpose: task-file command interpreter for sector writes and smart operations
// Assumes: host polls status or waits for the interrupt; register port as specified
// Notes:   media is modelled by a timer; erase state per sector kept by the host side
//
// Contract
// R01 - sector count 1..256 per write; zero means 256 sectors
// R02 - write 30h starts at sector number, cylinder and head in task file
// R03 - on accept set busy, then raise data request and drop busy
// R04 - no interrupt before the first sector data transfer
// R05 - host moves no data until busy seen low after command
// R06 - between sectors busy with no request, then request plus interrupt
// R07 - after last sector busy until done, then drop busy and interrupt
// R08 - on error stop at failing sector, keep its address in task file
// R09 - 38h uses the same protocol but skips the implied erase
// R10 - no-erase write on a sector not pre-erased falls back to normal write
// R11 - host should erase sectors before the no-erase write
// R12 - feature value selects smart sub-operation d0h..dah
// R13 - unsupported smart feature values are aborted
// R14 - smart enable and disable gate access to smart operations
// R15 - smart enable setting survives power cycling
// R16 - return status with spares below threshold gives f4h and 2ch
// R17 - return status with no threshold exceeded gives 4fh and c2h
// R18 - drive/head: bits 7 and 5 fixed one, bit 6 lba, bit 4 drive, 3..0 head
// R19 - each sector is 512 bytes as 16-bit words while request is set
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "atsw_params.svh"
module atsw_cmd_core (
	// clock and reset
	input  wire logic               clock_in,
	input  wire logic               rstn_in,
	// register port
	input  wire logic [3:0]         reg_addr_in,
	input  wire logic [15:0]        reg_wdata_in,
	input  wire logic               reg_wr_in,
	input  wire logic               reg_rd_in,
	output logic [15:0]             reg_rdata_out,
	// media status
	input  wire logic               media_fail_in,
	input  wire logic               sector_erased_in,
	input  wire logic               spares_low_in,
	// nonvolatile smart setting
	input  wire logic               nv_smart_en_in,
	output logic                    nv_smart_wr_out,
	output logic                    nv_smart_val_out,
	// sector data toward media
	output logic [15:0]             media_word_out,
	output logic                    media_word_vld_out,
	output logic                    media_erase_out,
	// interrupt
	output logic                    irq_out
);
	import atsw_pkg::*;

	atsw_state_e state_q, state_d;
	atsw_byte_t  feature_q, seccnt_q, secnum_q, cyl_lo_q, cyl_hi_q, drvhead_q;
	atsw_byte_t  error_q;
	logic [8:0]  remain_q;
	logic [7:0]  word_cnt_q;
	logic        bsy_q, drq_q, err_q, no_erase_q;
	logic [2:0]  irq_stat_q, irq_mask_q;
	logic        smart_en_q, nv_loaded_q;
	logic        timer_start_q;
	logic [7:0]  timer_cyc_q;
	logic        timer_done;

	function automatic logic [8:0] count_of(input atsw_byte_t cnt);
		count_of = (cnt == 8'h00) ? `ATSW_SEC_256 : {1'b0, cnt}; // [R01]
	endfunction : count_of

	function automatic logic feat_known(input atsw_byte_t f);
		feat_known = (f == `ATSW_FEAT_RD_DATA) || (f == `ATSW_FEAT_RD_THR)
			|| (f == `ATSW_FEAT_AUTOSAVE) || (f == `ATSW_FEAT_SAVE_ATTR)
			|| (f == `ATSW_FEAT_OFFLINE) || (f == `ATSW_FEAT_ENABLE)
			|| (f == `ATSW_FEAT_DISABLE) || (f == `ATSW_FEAT_STATUS); // [R12]
	endfunction : feat_known

	// register decode
	wire wr_data    = reg_wr_in && (reg_addr_in == `ATSW_OFS_DATA);
	wire wr_feature = reg_wr_in && (reg_addr_in == `ATSW_OFS_FEATURE);
	wire wr_seccnt  = reg_wr_in && (reg_addr_in == `ATSW_OFS_SECCNT);
	wire wr_secnum  = reg_wr_in && (reg_addr_in == `ATSW_OFS_SECNUM);
	wire wr_cyl_lo  = reg_wr_in && (reg_addr_in == `ATSW_OFS_CYL_LO);
	wire wr_cyl_hi  = reg_wr_in && (reg_addr_in == `ATSW_OFS_CYL_HI);
	wire wr_drvhead = reg_wr_in && (reg_addr_in == `ATSW_OFS_DRVHEAD);
	wire wr_cmd     = reg_wr_in && (reg_addr_in == `ATSW_OFS_CMD_STAT);
	wire wr_irq_clr = reg_wr_in && (reg_addr_in == `ATSW_OFS_IRQ_STAT);
	wire wr_irq_msk = reg_wr_in && (reg_addr_in == `ATSW_OFS_IRQ_MASK);

	wire        idle       = (state_q == ATSW_IDLE);
	wire        tf_write   = idle && !bsy_q;
	wire [7:0]  cmd_code   = reg_wdata_in[7:0];
	wire        is_write   = (cmd_code == `ATSW_CMD_WRITE) || (cmd_code == `ATSW_CMD_WRITE_NOER);
	wire        is_smart   = (cmd_code == `ATSW_CMD_SMART);
	wire        start_wr   = wr_cmd && tf_write && is_write;
	wire        smart_cmd  = wr_cmd && tf_write && is_smart;
	wire        smart_bad  = !feat_known(feature_q); // [R13]
	wire        smart_gate = !smart_en_q && (feature_q != `ATSW_FEAT_ENABLE); // [R14]
	wire        smart_abrt = smart_cmd && (smart_bad || smart_gate);
	wire        smart_stat = smart_cmd && !smart_abrt && (feature_q == `ATSW_FEAT_STATUS);
	wire        bad_cmd    = wr_cmd && tf_write && !is_write && !is_smart;
	wire        data_take  = wr_data && drq_q && (state_q == ATSW_XFER); // [R05] [R19]
	wire        last_word  = data_take && (word_cnt_q == `ATSW_WORDS_PER_SEC);
	wire        last_sec   = (remain_q == 9'h001);
	wire        erase_need = !no_erase_q || !sector_erased_in; // [R09] [R10]

	wire [7:0] status_byte = {bsy_q, !bsy_q, 2'b00, drq_q, 2'b00, err_q};
	wire [7:0] drvhead_rd  = {1'b1, drvhead_q[`ATSW_DH_LBA], 1'b1,
		drvhead_q[`ATSW_DH_DRV], drvhead_q[3:0]}; // [R18]
	wire [8:0] next_lba_lo = {1'b0, secnum_q} + 9'h001;

	atsw_media_timer u_timer (
		.clock_in  (clock_in),
		.rstn_in   (rstn_in),
		.start_in  (timer_start_q),
		.cycles_in (timer_cyc_q),
		.done_out  (timer_done)
	);

	// sequencing of one write command
	always_comb begin
		state_d = state_q;
		case (state_q)
			ATSW_IDLE:  if (start_wr) state_d = ATSW_SETUP; // [R03]
			ATSW_SETUP: state_d = ATSW_XFER;
			ATSW_XFER:  if (last_word) state_d = erase_need ? ATSW_ERASE : ATSW_PROG;
			ATSW_ERASE: if (timer_done) state_d = ATSW_PROG;
			ATSW_PROG: begin
				if (timer_done) begin
					if (media_fail_in || last_sec) state_d = ATSW_DONE; // [R08]
					else state_d = ATSW_XFER;
				end
			end
			ATSW_DONE:  state_d = ATSW_IDLE;
			default:    state_d = ATSW_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) state_q <= ATSW_IDLE;
		else state_q <= state_d;
	end

	// busy, request and error flags
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			bsy_q <= 1'b0;
			drq_q <= 1'b0;
			err_q <= 1'b0;
			error_q <= 8'h00;
		end else begin
			if (start_wr || smart_cmd || bad_cmd) begin
				bsy_q <= 1'b1; // [R03]
				err_q <= 1'b0;
				error_q <= 8'h00;
			end
			if (state_q == ATSW_SETUP) begin
				bsy_q <= 1'b0; // [R03] [R04]
				drq_q <= 1'b1;
			end
			if (last_word) begin
				bsy_q <= 1'b1; // [R06] [R07]
				drq_q <= 1'b0;
			end
			if (state_q == ATSW_PROG && timer_done) begin
				if (media_fail_in) begin
					err_q <= 1'b1; // [R08]
					error_q[`ATSW_ERR_IDNF] <= 1'b1;
				end else if (!last_sec) begin
					bsy_q <= 1'b0; // [R06]
					drq_q <= 1'b1;
				end
			end
			if (state_q == ATSW_DONE) bsy_q <= 1'b0; // [R07]
			if (bsy_q && idle && !start_wr && !smart_cmd && !bad_cmd) bsy_q <= 1'b0;
			if (bad_cmd || smart_abrt) begin
				err_q <= 1'b1; // [R13]
				error_q[`ATSW_ERR_ABRT] <= 1'b1;
			end
		end
	end

	// task file registers and sector address advance
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			feature_q <= 8'h00;
			seccnt_q  <= 8'h01;
			secnum_q  <= 8'h01;
			cyl_lo_q  <= 8'h00;
			cyl_hi_q  <= 8'h00;
			drvhead_q <= 8'ha0;
			no_erase_q <= 1'b0;
		end else begin
			if (wr_feature && tf_write) feature_q <= reg_wdata_in[7:0];
			if (wr_seccnt && tf_write)  seccnt_q  <= reg_wdata_in[7:0];
			if (wr_secnum && tf_write)  secnum_q  <= reg_wdata_in[7:0]; // [R02]
			if (wr_cyl_lo && tf_write)  cyl_lo_q  <= reg_wdata_in[7:0];
			if (wr_cyl_hi && tf_write)  cyl_hi_q  <= reg_wdata_in[7:0];
			if (wr_drvhead && tf_write) drvhead_q <= reg_wdata_in[7:0]; // [R18]
			if (start_wr) no_erase_q <= (cmd_code == `ATSW_CMD_WRITE_NOER); // [R09]
			if (smart_stat) begin
				cyl_lo_q <= spares_low_in ? `ATSW_SIG_BAD_LO : `ATSW_SIG_OK_LO; // [R16] [R17]
				cyl_hi_q <= spares_low_in ? `ATSW_SIG_BAD_HI : `ATSW_SIG_OK_HI; // [R16] [R17]
			end
			// failing sector keeps its address; good sectors other than the last advance it
			if (state_q == ATSW_PROG && timer_done && !media_fail_in) begin // [R08]
				seccnt_q <= seccnt_q - 8'h01;
				if (!last_sec) begin
					secnum_q <= next_lba_lo[7:0];
					if (next_lba_lo[8]) {cyl_hi_q, cyl_lo_q} <= {cyl_hi_q, cyl_lo_q} + 16'h0001;
				end
			end
		end
	end

	// sector and word counters, media strobes
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			remain_q <= 9'h000;
			word_cnt_q <= 8'h00;
			timer_start_q <= 1'b0;
			timer_cyc_q <= 8'h00;
			media_word_out <= 16'h0000;
			media_word_vld_out <= 1'b0;
			media_erase_out <= 1'b0;
		end else begin
			timer_start_q <= 1'b0;
			media_word_vld_out <= data_take;
			media_erase_out <= 1'b0;
			if (data_take) media_word_out <= reg_wdata_in;
			if (start_wr) begin
				remain_q <= count_of(seccnt_q); // [R01]
				word_cnt_q <= 8'h00;
			end
			if (data_take) word_cnt_q <= word_cnt_q + 8'h01; // [R19]
			if (last_word) begin
				timer_start_q <= 1'b1;
				timer_cyc_q <= erase_need ? 8'(`ATSW_ERASE_CYC) : 8'(`ATSW_PROG_CYC);
				media_erase_out <= erase_need; // [R10]
			end
			if (state_q == ATSW_ERASE && timer_done) begin
				timer_start_q <= 1'b1;
				timer_cyc_q <= 8'(`ATSW_PROG_CYC);
			end
			if (state_q == ATSW_PROG && timer_done) remain_q <= remain_q - 9'h001;
		end
	end

	// smart enable, mirrored into nonvolatile storage
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			smart_en_q <= 1'b0;
			nv_loaded_q <= 1'b0;
			nv_smart_wr_out <= 1'b0;
			nv_smart_val_out <= 1'b0;
		end else begin
			nv_smart_wr_out <= 1'b0;
			if (!nv_loaded_q) begin
				smart_en_q <= nv_smart_en_in; // [R15]
				nv_loaded_q <= 1'b1;
			end else if (smart_cmd && !smart_abrt) begin
				if (feature_q == `ATSW_FEAT_ENABLE || feature_q == `ATSW_FEAT_DISABLE) begin
					smart_en_q <= (feature_q == `ATSW_FEAT_ENABLE); // [R14]
					nv_smart_wr_out <= 1'b1; // [R15]
					nv_smart_val_out <= (feature_q == `ATSW_FEAT_ENABLE);
				end
			end
		end
	end

	// interrupt status: set wins over write-one-to-clear
	wire [2:0] irq_set = {
		bad_cmd || smart_abrt || (state_q == ATSW_PROG && timer_done && media_fail_in),
		state_q == ATSW_PROG && timer_done && !media_fail_in && !last_sec, // [R06]
		(state_q == ATSW_DONE) || (smart_cmd && !smart_abrt) // [R07]
	};

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			irq_stat_q <= 3'h0;
			irq_mask_q <= 3'h0;
			irq_out <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~(wr_irq_clr ? reg_wdata_in[2:0] : 3'h0)) | irq_set;
			if (wr_irq_msk) irq_mask_q <= reg_wdata_in[2:0];
			irq_out <= |(irq_stat_q & irq_mask_q);
		end
	end

	// read data, one cycle after the strobe
	logic [15:0] rd_mux;
	always_comb begin
		case (reg_addr_in)
			`ATSW_OFS_FEATURE:   rd_mux = 16'h0000;
			`ATSW_OFS_SECCNT:    rd_mux = {8'h00, seccnt_q};
			`ATSW_OFS_SECNUM:    rd_mux = {8'h00, secnum_q};
			`ATSW_OFS_CYL_LO:    rd_mux = {8'h00, cyl_lo_q};
			`ATSW_OFS_CYL_HI:    rd_mux = {8'h00, cyl_hi_q};
			`ATSW_OFS_DRVHEAD:   rd_mux = {8'h00, drvhead_rd};
			`ATSW_OFS_CMD_STAT:  rd_mux = {8'h00, status_byte};
			`ATSW_OFS_IRQ_STAT:  rd_mux = {13'h0000, irq_stat_q};
			`ATSW_OFS_IRQ_MASK:  rd_mux = {13'h0000, irq_mask_q};
			`ATSW_OFS_ERROR:     rd_mux = {8'h00, error_q};
			`ATSW_OFS_SMART_CFG: rd_mux = {15'h0000, smart_en_q};
			default:             rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) reg_rdata_out <= 16'h0000;
		else if (reg_rd_in) reg_rdata_out <= rd_mux;
		else reg_rdata_out <= 16'h0000;
	end
endmodule : atsw_cmd_core

// File: dv/atsw_cmd_core_monitor.sv
// Purpose: port assertions for the command core
// Assumes: bound to every atsw_cmd_core
// Notes:   helper logic tracks the last command and words per sector
`timescale 1ns/1ps
module atsw_cmd_core_monitor (
	// clock and reset
	input wire logic        clock_in,
	input wire logic        rstn_in,
	// register port
	input wire logic [3:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	// media, nv store and interrupt
	input wire logic        media_fail_in,
	input wire logic        sector_erased_in,
	input wire logic        spares_low_in,
	input wire logic        nv_smart_en_in,
	input wire logic        nv_smart_wr_out,
	input wire logic        nv_smart_val_out,
	input wire logic [15:0] media_word_out,
	input wire logic        media_word_vld_out,
	input wire logic        media_erase_out,
	input wire logic        irq_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	logic [7:0] cmd_q;
	logic [7:0] wcnt_q;
	logic       wait_q;
	wire        cmd_wr  = reg_wr_in && reg_addr_in == 4'h7;
	wire        irq_wr  = reg_wr_in && reg_addr_in[3:1] == 3'h4;
	wire        last_wd = media_word_vld_out && wcnt_q == 8'hff;
	wire [7:0]  cmd_v   = reg_wdata_in[7:0];
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			cmd_q  <= 8'h00;
			wcnt_q <= 8'h00;
			wait_q <= 1'b0;
		end else if (cmd_wr) begin
			cmd_q  <= cmd_v;
			wcnt_q <= 8'h00;
			wait_q <= cmd_v == 8'h30 || cmd_v == 8'h38;
		end else if (media_word_vld_out) begin
			wcnt_q <= wcnt_q + 8'h01;
			wait_q <= 1'b0;
		end
	end
	word_strobe_a: assert property (
		media_word_vld_out |-> $past(reg_wr_in && reg_addr_in == 4'h0))
		else $error("word strobe without a data write");
	word_value_a: assert property (
		media_word_vld_out |-> media_word_out == $past(reg_wdata_in))
		else $error("media word differs from written data");
	erase_needed_a: assert property (
		last_wd && (cmd_q == 8'h30 || !$past(sector_erased_in)) |-> media_erase_out)
		else $error("implied erase missing");
	erase_skip_a: assert property (
		media_erase_out |-> cmd_q == 8'h30 || !$past(sector_erased_in))
		else $error("erase on a pre-erased no-erase sector");
	erase_at_end_a: assert property (media_erase_out |-> last_wd)
		else $error("erase not on the last word of a sector");
	no_early_irq_a: assert property (wait_q |-> !$rose(irq_out))
		else $error("interrupt before the first data transfer");
	irq_sticky_a: assert property (irq_out && !irq_wr && !$past(irq_wr) |=> irq_out)
		else $error("interrupt dropped without a clear");
	nv_pulse_a: assert property (nv_smart_wr_out |=> !nv_smart_wr_out)
		else $error("nv store strobe longer than one cycle");
	nv_cause_a: assert property (nv_smart_wr_out |-> cmd_q == 8'hb0)
		else $error("nv store without a smart command");
	cover property (last_wd && media_erase_out);
	cover property (last_wd && !media_erase_out);
	cover property (nv_smart_wr_out && !nv_smart_val_out);
endmodule : atsw_cmd_core_monitor

bind atsw_cmd_core atsw_cmd_core_monitor mon_u (
	.clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .media_fail_in(media_fail_in),
	.sector_erased_in(sector_erased_in), .spares_low_in(spares_low_in),
	.nv_smart_en_in(nv_smart_en_in), .nv_smart_wr_out(nv_smart_wr_out),
	.nv_smart_val_out(nv_smart_val_out), .media_word_out(media_word_out),
	.media_word_vld_out(media_word_vld_out), .media_erase_out(media_erase_out),
	.irq_out(irq_out)
);

// File: dv/atsw_media_model.sv
// Purpose: media and nonvolatile store facing the command core
// Assumes: bench pulses clr_in before each write command
// Notes:   nv store ignores reset so the setting outlives a power cycle
`timescale 1ns/1ps
module atsw_media_model (
	// clock
	input wire logic        clock_in,
	// bench control
	input wire logic        clr_in,
	input wire logic [8:0]  fail_sec_in,
	input wire logic        erased_in,
	input wire logic        spares_in,
	// core side
	input wire logic        media_word_vld_in,
	input wire logic        nv_smart_wr_in,
	input wire logic        nv_smart_val_in,
	output logic            media_fail_out,
	output logic            sector_erased_out,
	output logic            spares_low_out,
	output logic            nv_smart_en_out
);
	logic [16:0] words_q = 17'h00000;
	initial nv_smart_en_out = 1'b1;
	always @(posedge clock_in) begin
		if (clr_in)
			words_q <= 17'h00000;
		else if (media_word_vld_in)
			words_q <= words_q + 17'h00001;
		if (nv_smart_wr_in)
			nv_smart_en_out <= nv_smart_val_in;
	end
	// words_q[16:8] is the count of finished sectors
	assign media_fail_out    = fail_sec_in != 9'h000 && words_q[16:8] == fail_sec_in;
	assign sector_erased_out = erased_in;
	assign spares_low_out    = spares_in;
endmodule : atsw_media_model

// File: dv/tb.sv
// Purpose: self-checking bench for the command core
// Assumes: media model holds the nonvolatile smart setting
// Notes:   random data and addresses come from an lfsr
`timescale 1ns/1ps
module tb;
	logic        clock_in = 1'b0;
	logic        rstn_in  = 1'b0;
	logic [3:0]  addr     = 4'h0;
	logic [15:0] wdata    = 16'h0000;
	logic        wr       = 1'b0;
	logic        rd       = 1'b0;
	logic        clr      = 1'b0;
	logic        erased   = 1'b0;
	logic        spares   = 1'b0;
	logic [8:0]  fail_sec = 9'h000;
	logic [31:0] lfsr     = 32'h000104e4;
	logic [15:0] rdata, mword, d;
	logic        fail, erased_o, spares_o, nv_en, nv_wr, nv_val, vld, erase, irq, ab, en;
	int          bad_count = 0;
	int          compares  = 0;
	logic [3:0]  ta [13] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc,
		4'h2, 4'h3, 4'h4, 4'h5, 4'ha, 4'h8};
	logic [7:0]  tv [13] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'ha0, 8'h40, 8'h00,
		8'hff, 8'h00, 8'h35, 8'h12, 8'h10, 8'h05};
	logic [7:0]  fl [14] = '{8'hd8, 8'hda, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4,
		8'he0, 8'hd9, 8'hda, 8'hd3, 8'hd8, 8'hda, 8'hd9};
	always #5 clock_in = ~clock_in;
	atsw_cmd_core dut_u (.clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.media_fail_in(fail), .sector_erased_in(erased_o), .spares_low_in(spares_o),
		.nv_smart_en_in(nv_en), .nv_smart_wr_out(nv_wr), .nv_smart_val_out(nv_val),
		.media_word_out(mword), .media_word_vld_out(vld), .media_erase_out(erase),
		.irq_out(irq));
	atsw_media_model mdl_u (.clock_in(clock_in), .clr_in(clr), .fail_sec_in(fail_sec),
		.erased_in(erased), .spares_in(spares), .media_word_vld_in(vld),
		.nv_smart_wr_in(nv_wr), .nv_smart_val_in(nv_val), .media_fail_out(fail),
		.sector_erased_out(erased_o), .spares_low_out(spares_o), .nv_smart_en_out(nv_en));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// return status signature as {cylinder high, cylinder low}
	function automatic logic [15:0] smart_sig(input logic low);
		return low ? 16'h2cf4 : 16'hc24f;
	endfunction : smart_sig
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock_in);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clock_in);
		wr    <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		@(posedge clock_in);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock_in);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic poll(input logic [7:0] exp);
		rd_reg(4'h7, d);
		for (int n = 0; n < 300 && d[7:0] !== exp; n++) begin
			rd_reg(4'h7, d);
		end
		chk("status", d[7:0], exp);
	endtask : poll
	task automatic send_sector();
		for (int w = 0; w < 256; w++) begin
			@(posedge clock_in);
			addr  <= 4'h0;
			wdata <= lfsr[15:0];
			wr    <= 1'b1;
			lfsr = lfsr_next(lfsr);
		end
		@(posedge clock_in);
		wr <= 1'b0;
	endtask : send_sector
	task automatic write_cmd(input logic [7:0] op, cnt, sn, input logic [15:0] cyl,
		input logic [7:0] fin);
		wr_reg(4'h2, {8'h00, cnt});
		wr_reg(4'h3, {8'h00, sn});
		wr_reg(4'h4, {8'h00, cyl[7:0]});
		wr_reg(4'h5, {8'h00, cyl[15:8]});
		clr <= 1'b1;
		wr_reg(4'h6, 16'h00e0);
		clr <= 1'b0;
		wr_reg(4'h7, {8'h00, op});
		poll(8'h48);
		rd_reg(4'h8, d);
		chk("first irq", d[7:0], 8'h00);
		send_sector();
		poll(8'h48);
		rd_reg(4'h8, d);
		chk("sector irq", d[7:0], 8'h02);
		wr_reg(4'h8, 16'h0007);
		send_sector();
		poll(fin);
	endtask : write_cmd
	task automatic do_reset();
		rstn_in <= 1'b0;
		repeat (20) @(posedge clock_in);
		rstn_in <= 1'b1;
		repeat (2) @(posedge clock_in);
	endtask : do_reset
	// hang guard
	initial begin
		#900000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		do_reset();
		for (int i = 0; i < 7; i++) begin
			rd_reg(ta[i], d);
			chk("reset value", d[7:0], tv[i]);
		end
		wr_reg(4'h6, 16'h004f);
		rd_reg(4'h6, d);
		chk("drive head", d[7:0], 8'hef);
		wr_reg(4'h9, 16'h0007);
		for (int c = 0; c < 3; c++) begin
			erased <= c == 0 ? lfsr[0] : c == 1;
			write_cmd(c ? 8'h38 : 8'h30, 8'h02, lfsr[7:0], lfsr[31:16], 8'h40);
			rd_reg(4'h8, d);
			chk("done irq", d[7:0], 8'h01);
			chk("irq pin", {7'h00, irq}, 8'h01);
			wr_reg(4'h8, 16'h0007);
			rd_reg(4'h8, d);
			chk("irq pin", {7'h00, irq}, 8'h00);
		end
		fail_sec <= 9'h002;
		write_cmd(8'h30, 8'h00, 8'hff, 16'h1234, 8'h41);
		for (int i = 7; i < 13; i++) begin
			rd_reg(ta[i], d);
			chk("fail task file", d[7:0], tv[i]);
		end
		fail_sec <= 9'h000;
		wr_reg(4'h8, 16'h0007);
		wr_reg(4'h9, 16'h0000);
		wr_reg(4'h1, 16'h00d8);
		wr_reg(4'h7, 16'h00b0);
		poll(8'h40);
		rd_reg(4'h8, d);
		chk("masked irq", {d[0], irq}, 8'h02);
		wr_reg(4'h9, 16'h0007);
		rd_reg(4'h9, d);
		chk("unmasked irq", {7'h00, irq}, 8'h01);
		wr_reg(4'h8, 16'h0007);
		en = 1'b1;
		spares <= lfsr[0];
		for (int i = 0; i < 14; i++) begin
			ab = fl[i] == 8'he0 || (!en && fl[i] != 8'hd8);
			// flip only on accepted status commands so both signatures are seen
			if (fl[i] == 8'hda && !ab)
				spares <= ~spares;
			wr_reg(4'h1, {8'h00, fl[i]});
			wr_reg(4'h7, 16'h00b0);
			poll(ab ? 8'h41 : 8'h40);
			rd_reg(4'h8, d);
			chk("abort irq", {7'h00, d[2]}, {7'h00, ab});
			wr_reg(4'h8, 16'h0007);
			if (!ab && fl[i] == 8'hda) begin
				rd_reg(4'h4, d);
				chk("sig low", d[7:0], 8'(smart_sig(spares)));
				rd_reg(4'h5, d);
				chk("sig high", d[7:0], 8'(smart_sig(spares) >> 8));
			end
			if (!ab && fl[i][7:1] == 7'h6c)
				en = !fl[i][0];
			rd_reg(4'hb, d);
			chk("smart enable", d[7:0], {7'h00, en});
		end
		do_reset();
		rd_reg(4'hb, d);
		chk("smart kept", d[7:0], {7'h00, en});
		tally_and_finish();
	end
endmodule : tb
